/* File: hdl/vip_pkg.sv */
package vip_pkg;

  localparam int NUM_SRC    = 64;
  localparam int NUM_VEC    = 44;
  localparam int NUM_EXT    = 5;
  localparam int NUM_PWORD  = 11;
  localparam int ADR_W      = 12;

  // register index = wb_adr_i[11:4], operation = wb_adr_i[3:2]
  localparam logic [7:0] IDX_CON    = 8'h00;
  localparam logic [7:0] IDX_STAT   = 8'h01;
  localparam logic [7:0] IDX_FLAG0  = 8'h03;
  localparam logic [7:0] IDX_EN0    = 8'h06;
  localparam logic [7:0] IDX_PRIO0  = 8'h09;
  localparam logic [7:0] IDX_BASE   = 8'h20;
  localparam logic [7:0] IDX_SPACE  = 8'h21;

  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLR   = 2'h1;
  localparam logic [1:0] OP_SET   = 2'h2;
  localparam logic [1:0] OP_INV   = 2'h3;

  // control word fields
  localparam int CON_MVEC_BIT = 12;
  localparam int CON_TPC_LSB  = 8;
  localparam int CON_EP_LSB   = 0;
  localparam logic [31:0] CON_MASK = 32'h0000_171f;
  localparam logic [31:0] CON_RST  = 32'h0000_0000;

  // status word fields
  localparam int STAT_RIPL_LSB = 8;
  localparam int STAT_VEC_LSB  = 0;

  // priority word slots: priority bits 4:2, subpriority bits 1:0, four slots
  localparam int SLOT_STRIDE = 8;
  localparam logic [31:0] PRIO_MASK = 32'h1f1f_1f1f;
  localparam logic [31:0] PRIO_RST  = 32'h0000_0000;

  localparam logic [31:0] BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] SPACE_RST = 32'h0000_0020;
  localparam logic [31:0] SPACE_MASK = 32'h0000_ffff;

  // external pin sources
  localparam logic [5:0] EXT_SRC [NUM_EXT] = '{6'h03, 6'h08, 6'h0d, 6'h12, 6'h17};

  // persistent sources re-raise their flag while the condition holds
  localparam logic [63:0] PERSIST = 64'h0fff_fff8_1631_8c60;

  // source to vector map, index is the source number
  localparam logic [5:0] SRC_VEC [NUM_SRC] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h05, 6'h06,
    6'h07, 6'h08, 6'h09, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
    6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h11, 6'h12, 6'h13,
    6'h14, 6'h15, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a,
    6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h1f, 6'h1f, 6'h20,
    6'h20, 6'h20, 6'h21, 6'h21, 6'h21, 6'h22, 6'h22, 6'h22,
    6'h23, 6'h23, 6'h24, 6'h24, 6'h24, 6'h25, 6'h25, 6'h25,
    6'h26, 6'h26, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2b};

  typedef struct packed {
    logic        req;
    logic [2:0]  ripl;
    logic [5:0]  vec;
    logic [31:0] addr;
  } vip_cpu_req_s;

endpackage : vip_pkg

/* File: hdl/vip_top.sv */
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module vip_top (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [vip_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic [vip_pkg::NUM_SRC-1:0] src_req,
  input  wire logic [vip_pkg::NUM_EXT-1:0] ext_pin,
  output vip_pkg::vip_cpu_req_s           cpu_irq
);
  import vip_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [31:0] con_ff;
  logic [31:0] flag_ff  [2];
  logic [31:0] en_ff    [2];
  logic [31:0] prio_ff  [NUM_PWORD];
  logic [31:0] base_ff;
  logic [31:0] space_ff;
  logic [31:0] stat_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;

  wire         bus_take = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire         bus_wr   = bus_take & wb_we_i;
  wire [7:0]   reg_idx  = wb_adr_i[ADR_W-1:4];
  wire [1:0]   reg_op   = wb_adr_i[3:2];
  wire [31:0]  byte_msk = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  wire         hit_con   = (reg_idx == IDX_CON);
  wire         hit_stat  = (reg_idx == IDX_STAT);
  wire         hit_base  = (reg_idx == IDX_BASE);
  wire         hit_space = (reg_idx == IDX_SPACE);
  wire [1:0]   hit_flag;
  wire [1:0]   hit_en;
  wire [NUM_PWORD-1:0] hit_prio;

  // write, clear, set or invert under byte enables and a field mask
  function automatic logic [31:0] vip_wr(input logic [31:0] cur,
                                         input logic [31:0] wd,
                                         input logic [1:0]  op,
                                         input logic [31:0] msk);
    logic [31:0] res;
    res = cur;
    unique case (op)
      OP_WRITE: res = wd;
      OP_CLR:   res = cur & ~wd;
      OP_SET:   res = cur | wd;
      OP_INV:   res = cur ^ wd;
    endcase
    return (cur & ~msk) | (res & msk);
  endfunction : vip_wr

  ////////////////////////////////////////////////////////////////////////////
  // external pin synchronisers and edge select

  logic [NUM_EXT-1:0] pin_s1_ff;
  logic [NUM_EXT-1:0] pin_s2_ff;
  logic [NUM_EXT-1:0] pin_s3_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= ext_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  wire [NUM_EXT-1:0] ext_pol  = con_ff[CON_EP_LSB +: NUM_EXT];
  wire [NUM_EXT-1:0] ext_rise = pin_s2_ff & ~pin_s3_ff;
  wire [NUM_EXT-1:0] ext_fall = ~pin_s2_ff & pin_s3_ff;
  wire [NUM_EXT-1:0] ext_evt  = (ext_pol & ext_rise) | (~ext_pol & ext_fall);

  ////////////////////////////////////////////////////////////////////////////
  // hardware request events

  logic [NUM_SRC-1:0] req_d_ff;
  logic [NUM_SRC-1:0] ext_set;
  logic [NUM_SRC-1:0] is_ext;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_d_ff <= '0;
    end else begin
      req_d_ff <= src_req;
    end
  end

  always_comb begin
    ext_set = '0;
    is_ext  = '0;
    for (int e = 0; e < NUM_EXT; e++) begin
      ext_set[EXT_SRC[e]] = ext_evt[e];
      is_ext[EXT_SRC[e]]  = 1'b1;
    end
  end

  // persistent sources follow the level, others take the rising edge, except the external sources, which take their pin event
  wire [NUM_SRC-1:0] lvl_set = src_req & PERSIST;
  wire [NUM_SRC-1:0] edg_set = src_req & ~req_d_ff & ~PERSIST;
  wire [NUM_SRC-1:0] hw_set  = ((lvl_set | edg_set) & ~is_ext) | ext_set;

  ////////////////////////////////////////////////////////////////////////////
  // flag and enable words

  logic [31:0] nxt_flag [2];
  logic [31:0] nxt_en   [2];

  genvar w;
  generate
    for (w = 0; w < 2; w++) begin : g_word
      assign hit_flag[w] = (reg_idx == IDX_FLAG0 + 8'(w));
      assign hit_en[w]   = (reg_idx == IDX_EN0 + 8'(w));
      // hardware set wins over a software clear in the same cycle
      assign nxt_flag[w] = ((bus_wr && hit_flag[w]) ?
                            vip_wr(flag_ff[w], wb_dat_i, reg_op, byte_msk) :
                            flag_ff[w]) | hw_set[32*w +: 32];
      assign nxt_en[w]   = (bus_wr && hit_en[w]) ?
                           vip_wr(en_ff[w], wb_dat_i, reg_op, byte_msk) : en_ff[w];

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          flag_ff[w] <= '0;
          en_ff[w]   <= '0;
        end else begin
          flag_ff[w] <= nxt_flag[w];
          en_ff[w]   <= nxt_en[w];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // priority words, four vector slots each

  genvar p;
  generate
    for (p = 0; p < NUM_PWORD; p++) begin : g_prio
      assign hit_prio[p] = (reg_idx == IDX_PRIO0 + 8'(p));
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          prio_ff[p] <= PRIO_RST;
        end else if (bus_wr && hit_prio[p]) begin
          prio_ff[p] <= vip_wr(prio_ff[p], wb_dat_i, reg_op, byte_msk & PRIO_MASK);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // control, table base and spacing

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      con_ff   <= CON_RST;
      base_ff  <= BASE_RST;
      space_ff <= SPACE_RST;
    end else if (bus_wr) begin
      if (hit_con) begin
        con_ff <= vip_wr(con_ff, wb_dat_i, reg_op, byte_msk & CON_MASK);
      end
      if (hit_base) begin
        base_ff <= vip_wr(base_ff, wb_dat_i, reg_op, byte_msk);
      end
      if (hit_space) begin
        space_ff <= vip_wr(space_ff, wb_dat_i, reg_op, byte_msk & SPACE_MASK);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ranking of pending enabled sources

  logic [4:0] src_key [NUM_SRC];
  logic [NUM_SRC-1:0] pend;

  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s++) begin : g_src
      wire [5:0] vec  = SRC_VEC[s];
      wire [3:0] widx = vec[5:2];
      wire [4:0] slot = 5'(vec[1:0]) * 5'd8;
      // slot fields: priority 4:2, subpriority 1:0
      assign src_key[s] = prio_ff[widx][slot +: 5];
      assign pend[s]    = flag_ff[s/32][s%32] & en_ff[s/32][s%32] &
                          (src_key[s][4:2] != 3'h0);
    end
  endgenerate

  logic [4:0] win_key;
  logic [5:0] win_src;
  logic       win_any;

  // scan downward so that the lowest source keeps an equal key
  always_comb begin
    win_key = '0;
    win_src = '0;
    win_any = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && (!win_any || src_key[i] >= win_key)) begin
        win_key = src_key[i];
        win_src = 6'(i);
        win_any = 1'b1;
      end
    end
  end

  wire        mvec     = con_ff[CON_MVEC_BIT];
  wire [5:0]  win_vec  = mvec ? SRC_VEC[win_src] : 6'h00;
  wire [21:0] vec_off  = 22'(win_vec) * 22'(space_ff[15:0]);
  wire [31:0] win_addr = base_ff + 32'(vec_off);

  ////////////////////////////////////////////////////////////////////////////
  // request to the cpu and status

  vip_cpu_req_s cpu_ff;
  vip_cpu_req_s nxt_cpu;

  assign nxt_cpu.req  = win_any;
  assign nxt_cpu.ripl = win_any ? win_key[4:2] : 3'h0;
  assign nxt_cpu.vec  = win_any ? win_vec : 6'h00;
  assign nxt_cpu.addr = win_any ? win_addr : base_ff;

  wire [31:0] nxt_stat = (32'(cpu_ff.ripl) << STAT_RIPL_LSB) |
                         (32'(cpu_ff.vec) << STAT_VEC_LSB);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cpu_ff  <= '0;
      stat_ff <= '0;
    end else begin
      cpu_ff  <= nxt_cpu;
      stat_ff <= nxt_stat;
    end
  end

  assign cpu_irq = cpu_ff;

  ////////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_con) begin
      rd_mux = con_ff;
    end
    if (hit_stat) begin
      rd_mux = stat_ff;
    end
    if (hit_base) begin
      rd_mux = base_ff;
    end
    if (hit_space) begin
      rd_mux = space_ff;
    end
    for (int k = 0; k < 2; k++) begin
      if (hit_flag[k]) begin
        rd_mux = flag_ff[k];
      end
      if (hit_en[k]) begin
        rd_mux = en_ff[k];
      end
    end
    for (int k = 0; k < NUM_PWORD; k++) begin
      if (hit_prio[k]) begin
        rd_mux = prio_ff[k];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff  <= bus_take;
      rdat_ff <= (bus_take && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule : vip_top

`default_nettype wire

/* File: bench/vip_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module vip_top_assertions
  import vip_pkg::*;
(
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [vip_pkg::ADR_W-1:0]  wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire vip_pkg::vip_cpu_req_s      cpu_irq
);
  logic             mvec_ff;
  logic [31:0]      base_ff;
  logic [31:0]      space_ff;
  wire logic [7:0]  idx = wb_adr_i[11:4];
  wire logic        wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                              && wb_sel_i == 4'hf && wb_adr_i[3:2] == OP_WRITE;
  // shadow of mode, table base and spacing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mvec_ff  <= 1'b0;
      base_ff  <= BASE_RST;
      space_ff <= SPACE_RST;
    end else if (wr_take) begin
      if (idx == IDX_CON) mvec_ff <= wb_dat_i[CON_MVEC_BIT];
      if (idx == IDX_BASE) base_ff <= wb_dat_i;
      if (idx == IDX_SPACE) space_ff <= wb_dat_i & SPACE_MASK;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  reset_quiet_a: assert property (!$past(rst_n) |-> !wb_ack_o && !cpu_irq.req)
    else $error("outputs active after reset");
  prio_live_a: assert property (cpu_irq.req |-> cpu_irq.ripl != 3'h0)
    else $error("request with priority zero");
  vec_range_a: assert property (cpu_irq.req |-> cpu_irq.vec < NUM_VEC)
    else $error("vector out of range");
  single_vec_a: assert property (cpu_irq.req && !$past(mvec_ff) |-> cpu_irq.vec == 6'h00)
    else $error("nonzero vector in single-vector mode");
  vec_addr_a: assert property (cpu_irq.req |-> cpu_irq.addr ==
      $past(base_ff) + 32'(cpu_irq.vec) * $past(space_ff))
    else $error("vector address wrong");
  idle_base_a: assert property (!cpu_irq.req |-> cpu_irq.addr == $past(base_ff))
    else $error("idle address is not the base");
endmodule : vip_top_assertions
bind vip_top vip_top_assertions u_vip_chk (
  .core_clk (core_clk),
  .rst_n    (rst_n),
  .wb_cyc_i (wb_cyc_i),
  .wb_stb_i (wb_stb_i),
  .wb_we_i  (wb_we_i),
  .wb_adr_i (wb_adr_i),
  .wb_sel_i (wb_sel_i),
  .wb_dat_i (wb_dat_i),
  .wb_dat_o (wb_dat_o),
  .wb_ack_o (wb_ack_o),
  .cpu_irq  (cpu_irq)
);
`default_nettype wire

/* File: bench/vip_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vip_cpu_model
  import vip_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            delay,
  input  wire vip_pkg::vip_cpu_req_s cpu_irq,
  output vip_pkg::vip_cpu_req_s      seen_ff
);
  logic [3:0] wait_ff;
  // cpu takes a request once it has stood for delay cycles
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_ff <= 4'h0;
      seen_ff <= '0;
    end else if (!cpu_irq.req) begin
      wait_ff <= 4'h0;
    end else if (wait_ff == delay) begin
      seen_ff <= cpu_irq;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule : vip_cpu_model
`default_nettype wire

/* File: bench/tb_vectored_interrupt_prioritizer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_prioritizer;
  import vip_pkg::*;
  logic               core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0]   wb_adr_i;
  logic [3:0]         wb_sel_i, delay;
  logic [31:0]        wb_dat_i, wb_dat_o, seed, rd, base, space, con;
  logic [NUM_SRC-1:0] src_req, en, flags;
  logic [NUM_EXT-1:0] ext_pin, pol;
  logic [31:0]        prio [NUM_PWORD];
  vip_cpu_req_s       cpu_irq, seen, exp;
  int                 fail_count, tests_run;

  vip_top DUT (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_req(src_req), .ext_pin(ext_pin),
    .cpu_irq(cpu_irq));
  vip_cpu_model u_cpu (.core_clk(core_clk), .rst_n(rst_n), .delay(delay), .cpu_irq(cpu_irq),
    .seen_ff(seen));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // highest priority, subpriority, then lowest source number
  function automatic vip_cpu_req_s winner(logic [63:0] f, logic mv);
    vip_cpu_req_s r;
    logic [4:0]   k, best;
    logic [5:0]   v;
    r = '0;
    best = 5'h0;
    for (int s = 0; s < NUM_SRC; s++) begin
      v = SRC_VEC[s];
      k = prio[v / 4][8 * (v % 4) +: 5];
      if (f[s] && k[4:2] != 3'h0 && (!r.req || k > best)) begin
        best = k;
        r.req = 1'b1;
        r.ripl = k[4:2];
        r.vec = mv ? v : 6'h00;
      end
    end
    r.addr = base + (r.req ? 32'(r.vec) * space : 32'h0);
    return r;
  endfunction : winner
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic we, input logic [7:0] idx, input logic [1:0] op,
                     input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, op, 2'b00};
    wb_dat_i <= wd;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : bus
  task automatic chk32(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      fail_count++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, want);
    end
  endtask : chk32
  task automatic chk_irq(input vip_cpu_req_s got, input vip_cpu_req_s want);
    tests_run++;
    if (got !== want) begin
      fail_count++;
      $display("mismatch at %0t: cpu request %h, expected %h", $time, got, want);
    end
  endtask : chk_irq
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    seed = 32'hddbf93e6;
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, src_req, ext_pin} = '0;
    wb_sel_i = 4'hf;
    delay = 4'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b0, IDX_CON, OP_WRITE, 32'h0, rd);
    chk32(rd, CON_RST);
    bus(1'b0, IDX_SPACE, OP_WRITE, 32'h0, rd);
    chk32(rd, SPACE_RST);
    bus(1'b1, 8'h7f, OP_WRITE, rnd(), rd);
    bus(1'b0, 8'h7f, OP_WRITE, 32'h0, rd);
    chk32(rd, 32'h0);
    bus(1'b1, IDX_STAT, OP_WRITE, 32'hffff_ffff, rd);
    bus(1'b0, IDX_STAT, OP_WRITE, 32'h0, rd);
    chk32(rd, 32'h0);
    // hardware events: level for persistent, edge for the rest
    @(posedge core_clk);
    src_req <= 64'h0000_0009_1000_0011;
    bus(1'b0, IDX_FLAG0, OP_WRITE, 32'h0, rd);
    chk32(rd, 32'h1000_0011);
    bus(1'b0, IDX_FLAG0 + 8'h1, OP_WRITE, 32'h0, rd);
    chk32(rd, 32'h0000_0009);
    bus(1'b1, IDX_FLAG0, OP_CLR, 32'hffff_ffff, rd);
    bus(1'b1, IDX_FLAG0 + 8'h1, OP_CLR, 32'hffff_ffff, rd);
    bus(1'b0, IDX_FLAG0, OP_WRITE, 32'h0, rd);
    chk32(rd, 32'h1000_0000);
    bus(1'b0, IDX_FLAG0 + 8'h1, OP_WRITE, 32'h0, rd);
    chk32(rd, 32'h0000_0008);
    src_req <= '0;
    // external pins, each polarity in turn
    rd = rnd();
    for (int k = 0; k < 2; k++) begin
      pol = k ? ~rd[4:0] : rd[4:0];
      bus(1'b1, IDX_CON, OP_WRITE, {27'h0, pol}, con);
      ext_pin <= ~pol;
      repeat (6) @(posedge core_clk);
      bus(1'b1, IDX_FLAG0, OP_WRITE, 32'h0, con);
      ext_pin <= pol;
      repeat (6) @(posedge core_clk);
      bus(1'b0, IDX_FLAG0, OP_WRITE, 32'h0, con);
      chk32(con, 32'h0084_2108);
      bus(1'b1, IDX_FLAG0, OP_WRITE, 32'h0, con);
      ext_pin <= ~pol;
      repeat (6) @(posedge core_clk);
      bus(1'b0, IDX_FLAG0, OP_WRITE, 32'h0, con);
      chk32(con, 32'h0);
    end
    // invert under partial byte enables
    rd = rnd();
    bus(1'b1, IDX_PRIO0, OP_WRITE, rd, con);
    wb_sel_i <= 4'h6;
    bus(1'b1, IDX_PRIO0, OP_INV, 32'hffff_ffff, con);
    wb_sel_i <= 4'hf;
    bus(1'b0, IDX_PRIO0, OP_WRITE, 32'h0, con);
    chk32(con, (rd ^ 32'h00ff_ff00) & PRIO_MASK);
    // random ranking, every fourth round with all levels tied
    for (int it = 0; it < 40; it++) begin
      con = rnd() & 32'h1000;
      base = rnd();
      space = rnd() & SPACE_MASK;
      en = {rnd(), rnd()};
      flags = {rnd(), rnd()} & {rnd(), rnd()};
      delay <= 4'(rnd() & 32'h7);
      bus(1'b1, IDX_CON, OP_WRITE, con, rd);
      bus(1'b1, IDX_BASE, OP_WRITE, base, rd);
      bus(1'b1, IDX_SPACE, OP_WRITE, space, rd);
      for (int w = 0; w < NUM_PWORD; w++) begin
        prio[w] = (it % 4 == 0) ? 32'h1d1d_1d1d : rnd();
        bus(1'b1, IDX_PRIO0 + 8'(w), OP_WRITE, prio[w], rd);
        prio[w] = prio[w] & PRIO_MASK;
        bus(1'b0, IDX_PRIO0 + 8'(w), OP_WRITE, 32'h0, rd);
        chk32(rd, prio[w]);
      end
      for (int h = 0; h < 2; h++) begin
        bus(1'b1, IDX_EN0 + 8'(h), OP_WRITE, en[32 * h +: 32], rd);
        bus(1'b1, IDX_FLAG0 + 8'(h), OP_WRITE, 32'h0, rd);
        bus(1'b1, IDX_FLAG0 + 8'(h), OP_SET, flags[32 * h +: 32], rd);
      end
      repeat (2) @(posedge core_clk);
      exp = winner(flags & en, con[CON_MVEC_BIT]);
      chk_irq(cpu_irq, exp);
      bus(1'b0, IDX_STAT, OP_WRITE, 32'h0, rd);
      chk32(rd, {21'h0, exp.ripl, 2'h0, exp.vec});
      if (exp.req) begin
        repeat (10) @(posedge core_clk);
        chk_irq(seen, exp);
      end
    end
    close_out();
  end
endmodule : tb_vectored_interrupt_prioritizer
`default_nettype wire
